// >>> core/dch_pkg.sv
// constants, types and state layout of the dual card host control port
package dch_pkg;

  localparam int FRAME_BITS = 8;
  localparam int CMD_CARD_BIT = 7;
  localparam int CMD_ADDR_BIT = 6;
  localparam int CMD_DIV_LSB = 4;
  localparam int CMD_SYNC_BIT = 3;
  localparam int CMD_SUPPLY_BIT = 2;
  localparam int CMD_SCLK_BIT = 1;
  localparam int CMD_SDATA_BIT = 0;

  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;
  localparam logic [1:0] DIV_BY_8 = 2'h3;

  // source rising edges per card clock half period
  localparam logic [2:0] HALF_DIV_2 = 3'h1;
  localparam logic [2:0] HALF_DIV_4 = 3'h2;
  localparam logic [2:0] HALF_DIV_8 = 3'h4;

  localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  typedef enum logic [1:0] {
    DIR_IDLE,
    DIR_HOST_TO_CARD,
    DIR_CARD_TO_HOST
  } dch_dir_e;

  typedef struct packed {
    logic [1:0] divMode;
    logic syncMode;
    logic supplyOn;
    logic syncClock;
    logic syncData;
    logic [2:0] divCount;
    logic clockOut;
  } dch_card_s;

  localparam dch_card_s CARD_RESET = '{
    divMode: DIV_BY_1, syncMode: 1'b0, supplyOn: 1'b0, syncClock: 1'b0,
    syncData: 1'b1, divCount: 3'h0, clockOut: 1'b0};

  typedef struct packed {
    logic sclkQ;
    logic sourceQ;
    logic [2:0] bitCount;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic chipSelected;
    logic selectedCard;
    dch_card_s [1:0] card;
    dch_dir_e dir;
    logic intPending;
    logic [1:0] presenceQ;
    logic [1:0] overloadQ;
  } dch_state_s;

  typedef struct packed {
    logic dataIn;
    logic dataOut;
    logic dataOe;
  } dch_pin_s;

endpackage : dch_pkg

// >>> core/dch_control_port.sv
// serial control port, clock selector and data translator of the dual card interface
// Behaviour
// (R01) translator on: selected, chip select low, async
// (R02) sync card: data through serial shift paths
// (R03) pull-up active only on selected chip
// (R04) card clock is source divided 1,2,4,8
// (R05) sync mode: card clock from serial bus
// (R06) divided card clock has 50 percent duty
// (R07) chip select high disables all functions; here only serial frame, status output and data paths stop
// (R08) bus clock only times serial shifting
// (R09) status byte shifted out within same frame
// (R10) command bit six addresses one of two chips
// (R11) pull-up follows pull-up enable input
// (R12) system enables pull-up on one chip only
// (R13) pull-up enable input always driven externally
// (R14) low logic supply: supplies off, shutdown
// (R15) interrupt low on insertion, extraction, overload
// (R16) serial output released when not selected
module dch_control_port
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic chipSelectN,
  input wire logic spiClock,
  input wire logic spiDataIn,
  output logic spiDataOut,
  output logic spiDataOe,
  input wire logic chipAddress,
  input wire logic sourceClock,
  input wire dch_pkg::dch_pin_s hostData,
  output logic hostDataOut,
  output logic hostDataOe,
  input wire dch_pkg::dch_pin_s cardSideDataLine,
  output logic cardSideDataLineOut,
  output logic cardSideDataLineOe,
  input wire logic hostPullupEnable,
  output logic hostPullupOn,
  output logic cardAClockOut,
  output logic cardBClockOut,
  output logic cardASupplyOut,
  output logic cardBSupplyOut,
  input wire logic cardAPresenceIn,
  input wire logic cardBPresenceIn,
  input wire logic cardAOverloadIn,
  input wire logic cardBOverloadIn,
  input wire logic logicSupplyLow,
  output logic interruptN
);
  import dch_pkg::*;

  dch_state_s st;
  dch_state_s next_st;

  localparam dch_state_s STATE_RESET = '{
    sclkQ: 1'b0, sourceQ: 1'b0, bitCount: BIT_COUNT_RESET, shiftIn: SHIFT_RESET,
    shiftOut: SHIFT_RESET, chipSelected: 1'b0, selectedCard: 1'b0,
    card: {CARD_RESET, CARD_RESET}, dir: DIR_IDLE, intPending: 1'b0,
    presenceQ: 2'h0, overloadQ: 2'h0};

  logic sclkRise;
  logic sclkFall;
  logic sourceRise;
  logic [7:0] command;
  logic [7:0] status;
  logic [1:0] presenceNow;
  logic [1:0] overloadNow;
  logic cardEvent;
  logic translatorOn;
  logic syncActive;
  logic [2:0] halfCount;
  logic frameDone;

  always_comb
  begin
    next_st = st;
    presenceNow = {cardBPresenceIn, cardAPresenceIn};
    overloadNow = {cardBOverloadIn, cardAOverloadIn};
    // serial edges come only from the bus clock
    sclkRise = spiClock & ~st.sclkQ; // R08
    sclkFall = ~spiClock & st.sclkQ; // R08
    sourceRise = sourceClock & ~st.sourceQ;
    command = {st.shiftIn[6:0], spiDataIn};
    syncActive = st.card[st.selectedCard].syncMode;
    frameDone = 1'b0;
    halfCount = HALF_DIV_2;
    status = {st.presenceQ[1], st.presenceQ[0], st.overloadQ[1], st.overloadQ[0],
      st.intPending, cardSideDataLine.dataIn, st.chipSelected, st.selectedCard};

    next_st.sclkQ = spiClock;
    next_st.sourceQ = sourceClock;
    next_st.presenceQ = presenceNow;
    next_st.overloadQ = overloadNow;

    // serial frame
    if (chipSelectN)
    begin
      next_st.bitCount = BIT_COUNT_RESET; // R07
      next_st.shiftOut = status; // R09
    end
    else
    begin
      if (sclkRise)
      begin
        next_st.shiftIn = command;
        next_st.bitCount = st.bitCount + 3'h1;
        if (st.bitCount == 3'(FRAME_BITS - 1))
        begin
          frameDone = 1'b1;
          if (command[CMD_ADDR_BIT] == chipAddress) // R10
          begin
            next_st.chipSelected = 1'b1;
            next_st.selectedCard = command[CMD_CARD_BIT];
            next_st.card[command[CMD_CARD_BIT]].divMode = command[CMD_DIV_LSB +: 2];
            next_st.card[command[CMD_CARD_BIT]].syncMode = command[CMD_SYNC_BIT];
            next_st.card[command[CMD_CARD_BIT]].supplyOn = command[CMD_SUPPLY_BIT];
            next_st.card[command[CMD_CARD_BIT]].syncClock = command[CMD_SCLK_BIT]; // R05
            next_st.card[command[CMD_CARD_BIT]].syncData = command[CMD_SDATA_BIT]; // R02
          end
          else
          begin
            next_st.chipSelected = 1'b0; // R10
          end
        end
      end
      if (sclkFall)
      begin
        next_st.shiftOut = {st.shiftOut[6:0], 1'b0}; // R09
      end
    end

    // card events, set wins over clear
    cardEvent = (|(presenceNow ^ st.presenceQ)) | (|(overloadNow & ~st.overloadQ)); // R15
    if (frameDone && command[CMD_ADDR_BIT] == chipAddress)
    begin
      next_st.intPending = 1'b0;
    end
    if (cardEvent)
    begin
      next_st.intPending = 1'b1; // R15
    end

    // clock selector per card
    for (int i = 0; i < 2; i++)
    begin
      unique case (st.card[i].divMode)
        DIV_BY_2: halfCount = HALF_DIV_2;
        DIV_BY_4: halfCount = HALF_DIV_4;
        DIV_BY_8: halfCount = HALF_DIV_8;
        DIV_BY_1: halfCount = HALF_DIV_2;
      endcase
      if (st.card[i].syncMode)
      begin
        next_st.card[i].clockOut = st.card[i].syncClock; // R05
        next_st.card[i].divCount = 3'h0;
      end
      else if (st.card[i].divMode == DIV_BY_1)
      begin
        next_st.card[i].clockOut = sourceClock; // R04
        next_st.card[i].divCount = 3'h0;
      end
      else if (sourceRise)
      begin
        // toggling on rising edges only keeps duty at half
        if (st.card[i].divCount + 3'h1 >= halfCount)
        begin
          next_st.card[i].divCount = 3'h0;
          next_st.card[i].clockOut = ~st.card[i].clockOut; // R06
        end
        else
        begin
          next_st.card[i].divCount = st.card[i].divCount + 3'h1; // R04
        end
      end
    end

    // host to card level translator
    translatorOn = ~chipSelectN & st.chipSelected & ~syncActive; // R01
    if (!translatorOn)
    begin
      next_st.dir = DIR_IDLE; // R07
    end
    else
    begin
      unique case (st.dir)
        DIR_IDLE:
        begin
          if (!hostData.dataIn)
          begin
            next_st.dir = DIR_HOST_TO_CARD;
          end
          else if (!cardSideDataLine.dataIn)
          begin
            next_st.dir = DIR_CARD_TO_HOST;
          end
        end
        DIR_HOST_TO_CARD:
        begin
          if (hostData.dataIn)
          begin
            next_st.dir = DIR_IDLE;
          end
        end
        DIR_CARD_TO_HOST:
        begin
          if (cardSideDataLine.dataIn)
          begin
            next_st.dir = DIR_IDLE;
          end
        end
        default:
        begin
          next_st.dir = DIR_IDLE;
        end
      endcase
    end

    // low logic supply forces shutdown
    if (logicSupplyLow)
    begin
      next_st = STATE_RESET; // R14
      next_st.sclkQ = spiClock;
      next_st.sourceQ = sourceClock;
      next_st.presenceQ = presenceNow;
      next_st.overloadQ = overloadNow;
      next_st.intPending = st.intPending | cardEvent;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign spiDataOut = st.shiftOut[7]; // R09
  assign spiDataOe = ~chipSelectN; // R16
  assign hostDataOut = 1'b0;
  assign hostDataOe = (st.dir == DIR_CARD_TO_HOST); // R01
  assign cardSideDataLineOut = 1'b0;
  assign cardSideDataLineOe = (st.dir == DIR_HOST_TO_CARD)
    | (~chipSelectN & st.chipSelected & syncActive & ~st.card[st.selectedCard].syncData); // R02
  assign hostPullupOn = hostPullupEnable & st.chipSelected; // R03 R11
  assign cardAClockOut = st.card[0].clockOut;
  assign cardBClockOut = st.card[1].clockOut;
  assign cardASupplyOut = st.card[0].supplyOn & ~logicSupplyLow; // R14
  assign cardBSupplyOut = st.card[1].supplyOn & ~logicSupplyLow; // R14
  assign interruptN = ~st.intPending; // R15

endmodule : dch_control_port

// >>> test/dch_checker.sv
// assertions watching the control port pins
module dch_checker
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic chipSelectN,
  input wire logic spiDataOe,
  input wire logic hostPullupEnable,
  input wire logic hostPullupOn,
  input wire logic logicSupplyLow,
  input wire logic cardASupplyOut,
  input wire logic hostDataOe,
  input wire logic cardSideDataLineOe,
  input wire logic cardAPresenceIn,
  input wire logic interruptN,
  input wire logic sourceClock,
  input wire logic cardAClockOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_oe_follows_cs: assert property (spiDataOe == !chipSelectN)
    else $error("bad status enable");
  a_pullup_gated: assert property (!hostPullupEnable |-> !hostPullupOn)
    else $error("pull-up on while disabled");
  a_supply_cut: assert property (logicSupplyLow |-> !cardASupplyOut)
    else $error("supply on at low logic supply");
  a_host_idle: assert property (chipSelectN [*2] |-> !hostDataOe)
    else $error("host pin driven while deselected");
  a_card_idle: assert property (chipSelectN [*2] |-> !cardSideDataLineOe)
    else $error("card line driven while deselected");
  a_int_raised: assert property ($changed(cardAPresenceIn) |-> ##[1:4] !interruptN)
    else $error("no interrupt on presence change");
  a_int_cleared: assert property ($rose(interruptN) |-> !$past(chipSelectN, 2))
    else $error("interrupt cleared without command");
  a_clock_quiet: assert property ((chipSelectN && $stable(sourceClock) && !logicSupplyLow) [*3]
    |=> $stable(cardAClockOut)) else $error("card clock moved without cause");
endmodule : dch_checker

bind dch_control_port dch_checker u_chk (.clock(clock), .resetn(resetn),
  .chipSelectN(chipSelectN), .spiDataOe(spiDataOe), .hostPullupEnable(hostPullupEnable),
  .hostPullupOn(hostPullupOn), .logicSupplyLow(logicSupplyLow), .cardASupplyOut(cardASupplyOut),
  .hostDataOe(hostDataOe), .cardSideDataLineOe(cardSideDataLineOe),
  .cardAPresenceIn(cardAPresenceIn), .interruptN(interruptN), .sourceClock(sourceClock),
  .cardAClockOut(cardAClockOut));

// >>> test/dch_host_model.sv
// serial bus master model of the host controller
module dch_host_model
(
  input wire logic clock,
  input wire logic spiDataOut,
  input wire logic spiDataOe,
  output logic chipSelectN,
  output logic spiClock,
  output logic spiDataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic miso;
  assign miso = spiDataOe ? spiDataOut : 1'b0;
  initial
  begin
    chipSelectN = 1'b1;
    spiClock = 1'b0;
    spiDataIn = 1'b0;
  end
  task automatic hold(input logic v);
    @(posedge clock) chipSelectN <= v;
  endtask : hold
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] st);
    hold(1'b0);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clock) spiDataIn <= cmd[i];
      @(posedge clock) spiClock <= 1'b1;
      repeat (2) @(posedge clock);
      st[i] = miso;
      spiClock <= 1'b0;
    end
    repeat (3) @(posedge clock);
    chipSelectN <= 1'b1;
  endtask : xfer
endmodule : dch_host_model

// >>> test/tb_top.sv
// bench for the dual card host control port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dch_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sourceClock = 1'b0;
  logic srcRun = 1'b1;
  logic [1:0] ph = 2'h0;
  logic pullEn = 1'b0;
  logic chipAddr = 1'b0;
  logic presB = 1'b0;
  logic cardLow = 1'b0;
  logic presA = 1'b0;
  logic ovlB = 1'b0;
  logic supLow = 1'b0;
  logic hostLow = 1'b0;
  logic csN, sclk, mosi, miso, misoOe, hOe, cOe, pullOn, clkA, clkB, supA, supB, intN;
  logic [7:0] st;
  int err_total = 0;
  int checked = 0;
  dch_pin_s hPin, cPin;
  assign hPin = '{dataIn: !(hOe || hostLow), dataOut: 1'b0, dataOe: hostLow};
  assign cPin = '{dataIn: !(cOe || cardLow), dataOut: 1'b0, dataOe: cardLow};
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    sourceClock <= srcRun && (ph == 2'h0);
  end
  dch_control_port DUT (.clock(clock), .resetn(resetn), .chipSelectN(csN), .spiClock(sclk),
    .spiDataIn(mosi), .spiDataOut(miso), .spiDataOe(misoOe), .chipAddress(chipAddr),
    .sourceClock(sourceClock), .hostData(hPin), .hostDataOut(), .hostDataOe(hOe),
    .cardSideDataLine(cPin), .cardSideDataLineOut(), .cardSideDataLineOe(cOe),
    .hostPullupEnable(pullEn), .hostPullupOn(pullOn), .cardAClockOut(clkA),
    .cardBClockOut(clkB), .cardASupplyOut(supA), .cardBSupplyOut(supB), .cardAPresenceIn(presA),
    .cardBPresenceIn(presB), .cardAOverloadIn(1'b0), .cardBOverloadIn(ovlB),
    .logicSupplyLow(supLow), .interruptN(intN));
  dch_host_model host (.clock(clock), .spiDataOut(miso), .spiDataOe(misoOe),
    .chipSelectN(csN), .spiClock(sclk), .spiDataIn(mosi));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wt;
    repeat (5) @(negedge clock);
  endtask : wt
  task automatic wait_a(input logic v);
    for (int n = 0; n < 40 && clkA !== v; n++)
      @(negedge clock);
  endtask : wait_a
  task automatic t_pull;
    host.xfer(8'h00, st);
    pullEn <= 1'b1;
    wt;
    chk("pull-up", 8'h01, 8'(pullOn));
    @(posedge clock) pullEn <= 1'b0;
    wt;
    chk("pull-up", 8'h00, 8'(pullOn));
    host.xfer(8'h40, st);
    pullEn <= 1'b1;
    wt;
    chk("pull-up", 8'h00, 8'(pullOn));
    @(posedge clock) chipAddr <= 1'b1;
    host.xfer(8'h40, st);
    chipAddr <= 1'b0;
    wt;
    chk("pull-up", 8'h01, 8'(pullOn));
    $display("t_pull done");
  endtask : t_pull
  task automatic t_div;
    logic [7:0] hi, lo, e;
    for (int d = 0; d < 4; d++)
    begin
      host.xfer({2'h0, 2'(d), 4'h4}, st);
      e = (d == 0) ? 8'h01 : 8'h03 << (d - 1);
      hi = 8'h00;
      lo = 8'h00;
      @(negedge clock);
      wait_a(1'b0);
      wait_a(1'b1);
      for (; clkA === 1'b1 && hi < 8'h40; hi++)
        @(negedge clock);
      for (; clkA === 1'b0 && lo < 8'h40; lo++)
        @(negedge clock);
      chk("high span", e, hi);
      chk("low span", (d == 0) ? 8'h02 : e, lo);
    end
    $display("t_div done");
  endtask : t_div
  task automatic t_sync;
    host.xfer(8'h0e, st);
    repeat (6)
    begin
      @(negedge clock);
      chk("sync clock", 8'h01, 8'(clkA));
    end
    host.xfer(8'h8e, st);
    wt;
    chk("sync clock B", 8'h01, 8'(clkB));
    host.hold(1'b0);
    wt;
    chk("sync data", 8'h01, 8'(cOe));
    host.hold(1'b1);
    wt;
    chk("sync data", 8'h00, 8'(cOe));
    $display("t_sync done");
  endtask : t_sync
  task automatic t_xlat;
    host.xfer(8'h04, st);
    host.hold(1'b0);
    hostLow <= 1'b1;
    wt;
    chk("translator", 8'h01, 8'(cOe));
    @(posedge clock) hostLow <= 1'b0;
    wt;
    chk("translator", 8'h00, 8'(cOe));
    @(posedge clock) cardLow <= 1'b1;
    wt;
    chk("host drive", 8'h01, 8'(hOe));
    @(posedge clock) cardLow <= 1'b0;
    wt;
    chk("host drive", 8'h00, 8'(hOe));
    host.hold(1'b1);
    hostLow <= 1'b1;
    wt;
    chk("translator", 8'h00, 8'(cOe));
    @(posedge clock) hostLow <= 1'b0;
    $display("t_xlat done");
  endtask : t_xlat
  task automatic t_int;
    @(posedge clock) presA <= 1'b1;
    wt;
    chk("interrupt", 8'h00, 8'(intN));
    host.xfer(8'h00, st);
    chk("status", 8'h4c, st & 8'hfc);
    wt;
    chk("interrupt", 8'h01, 8'(intN));
    @(posedge clock) presB <= 1'b1;
    wt;
    chk("interrupt", 8'h00, 8'(intN));
    host.xfer(8'h00, st);
    chk("status", 8'hcc, st & 8'hfc);
    wt;
    chk("interrupt", 8'h01, 8'(intN));
    @(posedge clock) ovlB <= 1'b1;
    wt;
    chk("interrupt", 8'h00, 8'(intN));
    $display("t_int done");
  endtask : t_int
  task automatic t_sup;
    host.xfer(8'h04, st);
    srcRun <= 1'b0;
    wt;
    chk("supply", 8'h01, 8'(supA));
    chk("supply B", 8'h01, 8'(supB));
    @(posedge clock) supLow <= 1'b1;
    @(negedge clock) chk("supply", 8'h00, 8'(supA));
    chk("supply B", 8'h00, 8'(supB));
    @(posedge clock) supLow <= 1'b0;
    $display("t_sup done");
  endtask : t_sup
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_pull;
    t_div;
    t_sync;
    t_xlat;
    t_int;
    t_sup;
    conclude;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    conclude;
  end
endmodule : tb_top
